/* rtl/icd_pkg.sv */
// shared constants and types for the converter channel control link
package icd_pkg;
  // pointer byte mode field, upper four bits
  localparam logic [3:0] MODE_CFG = 4'h0;
  localparam logic [3:0] MODE_DAC_WR = 4'h1;
  localparam logic [3:0] MODE_ADC_RD = 4'h4;
  localparam logic [3:0] MODE_DAC_RD = 4'h5;
  // control register selectors, lower four bits
  localparam logic [3:0] REG_SEQ = 4'h2;
  localparam logic [3:0] REG_LOAD = 4'h7;
  localparam logic [3:0] REG_GPIO_SEL = 4'h8;
  localparam logic [3:0] REG_GPIO_DAT = 4'h9;
  localparam logic [3:0] REG_GPIO_OD = 4'hc;
  // load mode codes
  localparam logic [1:0] LOAD_NOW = 2'h0;
  localparam logic [1:0] LOAD_HOLD = 2'h1;
  localparam logic [1:0] LOAD_ALL = 2'h2;
  // sequence register layout
  localparam int SEQ_REP = 9;
  localparam int SEQ_W = 10;
  localparam logic [3:0] SLOT_NONE = 4'hf;
  // data word layout
  localparam int NCH = 8;
  localparam int DW = 12;
  localparam int WW = 16;
  localparam logic TAG_DAC = 1'b1;
  localparam logic TAG_ADC = 1'b0;
  // bit counter positions within a byte slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // host command kinds
  typedef enum logic [1:0] {
    CMD_WRITE, CMD_POINTER, CMD_READ
  } icd_cmd_t;
endpackage

/* rtl/icd_link_if.sv */
// two-wire link between host and device ends
`timescale 1ns/1ps
interface icd_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  // open-drain wire with pull-up: low wins
  assign sda = !((host_sda_oe && !host_sda_o) ||
                 (dev_sda_oe && !dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe,
                input sda);
  modport dev (input scl, output dev_sda_o, output dev_sda_oe,
               input sda);
endinterface

/* rtl/icd_device.sv */
// device end: bus slave, DAC registers, ADC sequencer, GPIO drive
`timescale 1ns/1ps
module icd_device #(
  parameter logic [6:0] BUS_ADDR = 7'h11 // arbitrary bus address
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // link
  icd_link_if.dev LINK,
  // converter
  input wire logic [11:0] I_ADC_DATA,
  output logic [3:0] O_ADC_CH,
  output logic O_ADC_START,
  output logic [95:0] O_DAC_CODES,
  // general pins
  output logic [7:0] O_IO_PIN_OUT,
  output logic [7:0] O_IO_PIN_OE
);
  typedef enum {
    D_IDLE, D_ADDR, D_PTR, D_MSB, D_LSB, D_RD, D_SKIP
  } icd_dst_t;

  icd_dst_t st_r;
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic [7:0] msb_r;
  logic [7:0] lsb_r;
  logic [15:0] tx_r;
  logic rd_lsb_r;
  logic sda_oe_r;
  logic wr_go_r;
  localparam int NCH_W = icd_pkg::NCH;
  logic [NCH_W-1:0][11:0] in_r;
  logic [NCH_W-1:0][11:0] dac_r;
  logic [1:0] load_r;
  logic [7:0] gsel_r;
  logic [7:0] gdat_r;
  logic [7:0] god_r;
  logic [icd_pkg::SEQ_W-1:0] seq_r;
  logic [3:0] cur_r;
  logic done_r;
  logic [15:0] res_r;
  logic start_r;
  logic [7:0] out_r;
  logic [7:0] oe_r;

  logic scl;
  logic sda;
  logic re;
  logic fe;
  logic start_c;
  logic stop_c;
  logic word_go;
  logic conv_ok;
  logic [15:0] adc_word;
  logic [15:0] wdata;
  logic [7:0] tbyte;
  logic [3:0] nxt_c;
  logic [3:0] first_c;

  // first selected slot at or above lo; temperature is slot 8
  function automatic logic [3:0] nxt_sel(input logic [8:0] sel,
                                         input logic [3:0] lo);
    logic [3:0] r;
    r = icd_pkg::SLOT_NONE;
    for (int i = 8; i >= 0; i--)
    begin
      if (sel[i] && 4'(i) >= lo)
        r = 4'(i);
    end
    return r;
  endfunction

  // two-stage synchronisers; only stage two and later are read
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], LINK.scl};
      sda_s_r <= {sda_s_r[0], LINK.sda};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  // link edge and condition detection
  assign scl = scl_s_r[1];
  assign sda = sda_s_r[1];
  assign re = scl && !scl_d_r;
  assign fe = !scl && scl_d_r;
  assign start_c = scl && scl_d_r && sda_d_r && !sda;
  assign stop_c = scl && scl_d_r && !sda_d_r && sda;
  // ack clock rise ahead of a result MSB
  assign word_go = re && bit_r == icd_pkg::BIT_ACK && st_r == D_RD &&
                   rd_lsb_r && !sda;
  assign conv_ok = seq_r[8:0] != 9'h000 && !done_r;
  assign adc_word = conv_ok ?
    {icd_pkg::TAG_ADC, cur_r[2:0], I_ADC_DATA} : res_r;
  assign wdata = {msb_r, lsb_r};
  assign tbyte = rd_lsb_r ? tx_r[7:0] : tx_r[15:8];
  assign nxt_c = nxt_sel(seq_r[8:0], cur_r + 4'h1);
  assign first_c = nxt_sel(wdata[8:0], 4'h0);

  // byte engine: shift in, ack, shift out
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      st_r <= D_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      msb_r <= 8'h00;
      lsb_r <= 8'h00;
      rd_lsb_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_go_r <= 1'b0;
    end
    else
    begin
      wr_go_r <= 1'b0;
      if (stop_c)
      begin
        st_r <= D_IDLE;
        sda_oe_r <= 1'b0;
      end
      else if (start_c)
      begin
        st_r <= D_ADDR;
        // all ones: the scl fall that ends the start steps to bit 0
        bit_r <= '1;
        sda_oe_r <= 1'b0;
      end
      else if (st_r != D_IDLE)
      begin
        if (re && bit_r < icd_pkg::BIT_ACK)
          sh_r <= {sh_r[6:0], sda};
        // master refuses further data
        if (re && bit_r == icd_pkg::BIT_ACK && st_r == D_RD && sda)
          st_r <= D_SKIP;
        if (fe && bit_r == icd_pkg::BIT_LAST)
        begin
          bit_r <= icd_pkg::BIT_ACK;
          sda_oe_r <= st_r inside {D_PTR, D_MSB, D_LSB};
          case (st_r)
            D_ADDR:
            begin
              if (sh_r[7:1] == BUS_ADDR)
              begin
                sda_oe_r <= 1'b1;
                st_r <= sh_r[0] ? D_RD : D_PTR;
                rd_lsb_r <= 1'b1;
              end
              else
                st_r <= D_SKIP;
            end
            D_PTR:
            begin
              ptr_r <= sh_r;
              st_r <= D_MSB;
            end
            D_MSB:
            begin
              msb_r <= sh_r;
              st_r <= D_LSB;
            end
            D_LSB:
            begin
              lsb_r <= sh_r;
              wr_go_r <= 1'b1;
              st_r <= D_SKIP; // extra bytes are not acked
            end
            default:
              sda_oe_r <= 1'b0;
          endcase
        end
        else if (fe && bit_r == icd_pkg::BIT_ACK)
        begin
          bit_r <= 4'h0;
          rd_lsb_r <= !rd_lsb_r;
          if (st_r == D_RD)
            sda_oe_r <= rd_lsb_r ? !tx_r[15] : !tx_r[7];
          else
            sda_oe_r <= 1'b0;
        end
        else if (fe)
        begin
          bit_r <= bit_r + 4'h1;
          sda_oe_r <= st_r == D_RD && !tbyte[3'(6 - bit_r)];
        end
      end
    end
  end

  // next result word, loaded at each word boundary of a read
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
      tx_r <= 16'h0000;
    else if (word_go)
    begin
      case (ptr_r[7:4])
        icd_pkg::MODE_DAC_RD:
          tx_r <= {icd_pkg::TAG_DAC, ptr_r[2:0],
                   in_r[ptr_r[2:0]]};
        icd_pkg::MODE_ADC_RD:
          tx_r <= adc_word;
        default:
          tx_r <= 16'h0000;
      endcase
    end
  end

  // input and DAC registers with load mode
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      in_r <= '0;
      dac_r <= '0;
      load_r <= icd_pkg::LOAD_NOW;
    end
    else
    begin
      if (load_r == icd_pkg::LOAD_ALL)
      begin
        dac_r <= in_r;
        load_r <= icd_pkg::LOAD_HOLD;
      end
      if (wr_go_r && ptr_r[7:4] == icd_pkg::MODE_DAC_WR)
      begin
        in_r[ptr_r[2:0]] <= wdata[11:0];
        // hold and reserved codes leave DAC untouched
        if (load_r == icd_pkg::LOAD_NOW)
          dac_r[ptr_r[2:0]] <= wdata[11:0];
      end
      if (wr_go_r && ptr_r == {icd_pkg::MODE_CFG, icd_pkg::REG_LOAD})
        load_r <= wdata[1:0];
    end
  end

  // general pin registers
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      gsel_r <= 8'h00;
      gdat_r <= 8'h00;
      god_r <= 8'h00;
    end
    else if (wr_go_r && ptr_r[7:4] == icd_pkg::MODE_CFG)
    begin
      case (ptr_r[3:0])
        icd_pkg::REG_GPIO_SEL:
          gsel_r <= wdata[7:0];
        icd_pkg::REG_GPIO_DAT:
          gdat_r <= (gdat_r & ~gsel_r) |
                    (wdata[7:0] & gsel_r);
        icd_pkg::REG_GPIO_OD:
          god_r <= wdata[7:0];
        default:
          ;
      endcase
    end
  end

  // pin drive; open drain only ever pulls low
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      out_r <= 8'h00;
      oe_r <= 8'h00;
    end
    else
    begin
      out_r <= gsel_r & ~god_r & gdat_r;
      oe_r <= gsel_r & (~god_r | ~gdat_r);
    end
  end

  // conversion sequencer; slot 8 is temperature
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      seq_r <= '0;
      cur_r <= icd_pkg::SLOT_NONE;
      done_r <= 1'b0;
      res_r <= 16'h0000;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      if (wr_go_r && ptr_r == {icd_pkg::MODE_CFG, icd_pkg::REG_SEQ})
      begin
        seq_r <= wdata[icd_pkg::SEQ_W-1:0];
        cur_r <= first_c;
        done_r <= 1'b0;
      end
      else if (word_go && ptr_r[7:4] == icd_pkg::MODE_ADC_RD && conv_ok)
      begin
        start_r <= 1'b1;
        res_r <= adc_word;
        if (nxt_c != icd_pkg::SLOT_NONE)
          cur_r <= nxt_c;
        else if (seq_r[icd_pkg::SEQ_REP])
          cur_r <= nxt_sel(seq_r[8:0], 4'h0);
        else
          done_r <= 1'b1;
      end
    end
  end

  // outputs straight from flops; the data line level is tied low
  assign O_ADC_CH = cur_r;
  assign O_ADC_START = start_r;
  assign O_DAC_CODES = dac_r;
  assign O_IO_PIN_OUT = out_r;
  assign O_IO_PIN_OE = oe_r;
  assign LINK.dev_sda_o = 1'b0;
  assign LINK.dev_sda_oe = sda_oe_r;
endmodule // icd_device

/* rtl/icd_host.sv */
// host end: command sequencer, bit engine and two-entry read buffer
`timescale 1ns/1ps
module icd_host #(
  parameter int CLK_DIV = 5, // clocks per quarter bit
  parameter logic [6:0] BUS_ADDR = 7'h11 // arbitrary bus address
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // link
  icd_link_if.host LINK,
  // commands
  input wire logic I_CMD_VALID,
  input wire icd_pkg::icd_cmd_t I_CMD_KIND,
  input wire logic [7:0] I_CMD_PTR,
  input wire logic [15:0] I_CMD_DATA,
  output logic O_CMD_READY,
  // read words
  output logic O_RD_VALID,
  output logic [15:0] O_RD_DATA,
  input wire logic I_RD_READY,
  output logic O_NACK
);
  typedef enum { H_IDLE, H_START, H_BYTE, H_STOP } icd_hst_t;

  // the device reacts three clocks after an edge; timer is 8 bits
  if (CLK_DIV < 4 || CLK_DIV > 256)
  begin : g_div_check
    $error("CLK_DIV must lie between 4 and 256");
  end

  icd_hst_t st_r;
  logic [7:0] tmr_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [8:0] bi_r;
  logic [8:0] nb_r;
  logic rd_r;
  logic [7:0] ptr_r;
  logic [15:0] dat_r;
  logic [7:0] tb_r;
  logic [7:0] rx_r;
  logic [7:0] hi_r;
  logic scl_r;
  logic oe_r;
  logic ready_r;
  logic nack_r;
  logic [1:0] sda_s_r;
  logic out_v_r;
  logic [15:0] out_d_r;
  logic sp_v_r;
  logic [15:0] sp_d_r;
  logic tick;
  logic push;
  logic pop;
  logic full;
  logic tx_byte;
  logic last_byte;
  logic stall;
  logic [7:0] next_tb;

  assign tick = tmr_r == 8'(CLK_DIV - 1);
  assign tx_byte = !rd_r || bi_r == 9'h000;
  assign last_byte = bi_r + 9'h001 == nb_r;
  assign full = out_v_r && sp_v_r;
  // hold the clock low before a word that has no room
  assign stall = st_r == H_BYTE && q_r == 2'h0 && bit_r == 4'h0 &&
                 !tx_byte && bi_r[0] && full;
  assign push = st_r == H_BYTE && tick && q_r == 2'h3 && !tx_byte &&
                bit_r == icd_pkg::BIT_ACK && !bi_r[0];
  assign pop = out_v_r && I_RD_READY;
  always_comb
  begin
    case (bi_r + 9'h001)
      9'h001: next_tb = ptr_r;
      9'h002: next_tb = dat_r[15:8];
      default: next_tb = dat_r[7:0];
    endcase
  end

  // data line synchroniser
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
      sda_s_r <= 2'h3;
    else
      sda_s_r <= {sda_s_r[0], LINK.sda};
  end

  // quarter bit timer
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || tick || st_r == H_IDLE || stall)
      tmr_r <= 8'h00;
    else
      tmr_r <= tmr_r + 8'h01;
  end

  // frame sequencer and bit engine
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      st_r <= H_IDLE;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      bi_r <= 9'h000;
      nb_r <= 9'h000;
      rd_r <= 1'b0;
      ptr_r <= 8'h00;
      dat_r <= 16'h0000;
      tb_r <= 8'h00;
      rx_r <= 8'h00;
      hi_r <= 8'h00;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      ready_r <= 1'b0;
      nack_r <= 1'b0;
    end
    else if (st_r == H_IDLE)
    begin
      nack_r <= 1'b0;
      ready_r <= !(ready_r && I_CMD_VALID);
      if (ready_r && I_CMD_VALID)
      begin
        st_r <= H_START;
        q_r <= 2'h0;
        rd_r <= I_CMD_KIND == icd_pkg::CMD_READ;
        ptr_r <= I_CMD_PTR;
        dat_r <= I_CMD_DATA;
        bi_r <= 9'h000;
        tb_r <= {BUS_ADDR, I_CMD_KIND == icd_pkg::CMD_READ};
        case (I_CMD_KIND)
          icd_pkg::CMD_WRITE: nb_r <= 9'h004;
          icd_pkg::CMD_POINTER: nb_r <= 9'h002;
          default: nb_r <= {I_CMD_DATA[7:0], 1'b1};
        endcase
      end
    end
    else if (tick)
    begin
      q_r <= q_r + 2'h1;
      case (st_r)
        H_START:
        begin
          if (q_r == 2'h1)
            oe_r <= 1'b1;
          if (q_r == 2'h2)
            scl_r <= 1'b0;
          if (q_r == 2'h3)
          begin
            st_r <= H_BYTE;
            bit_r <= 4'h0;
          end
        end
        H_BYTE:
        begin
          if (q_r == 2'h0)
            oe_r <= bit_r == icd_pkg::BIT_ACK ?
                    (!tx_byte && !last_byte) : (tx_byte && !tb_r[7]);
          if (q_r == 2'h1)
            scl_r <= 1'b1;
          if (q_r == 2'h2 && bit_r != icd_pkg::BIT_ACK)
            rx_r <= {rx_r[6:0], sda_s_r[1]};
          if (q_r == 2'h2 && bit_r == icd_pkg::BIT_ACK && tx_byte)
            nack_r <= sda_s_r[1];
          if (q_r == 2'h3)
          begin
            scl_r <= 1'b0;
            if (bit_r != icd_pkg::BIT_ACK)
            begin
              bit_r <= bit_r + 4'h1;
              tb_r <= {tb_r[6:0], 1'b0};
            end
            else
            begin
              bit_r <= 4'h0;
              bi_r <= bi_r + 9'h001;
              tb_r <= next_tb;
              if (bi_r[0])
                hi_r <= rx_r;
              if (last_byte || nack_r)
                st_r <= H_STOP;
            end
          end
        end
        default:
        begin
          if (q_r == 2'h0)
            oe_r <= 1'b1;
          if (q_r == 2'h1)
            scl_r <= 1'b1;
          if (q_r == 2'h2)
            oe_r <= 1'b0;
          if (q_r == 2'h3)
            st_r <= H_IDLE;
        end
      endcase
    end
  end

  // two-entry read buffer: output stage plus spare
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      out_v_r <= 1'b0;
      sp_v_r <= 1'b0;
      out_d_r <= 16'h0000;
      sp_d_r <= 16'h0000;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (!out_v_r)
          begin
            out_d_r <= {hi_r, rx_r};
            out_v_r <= 1'b1;
          end
          else
          begin
            sp_d_r <= {hi_r, rx_r};
            sp_v_r <= 1'b1;
          end
        end
        2'b01:
        begin
          if (sp_v_r)
          begin
            out_d_r <= sp_d_r;
            sp_v_r <= 1'b0;
          end
          else
            out_v_r <= 1'b0;
        end
        2'b11:
        begin
          if (sp_v_r)
          begin
            out_d_r <= sp_d_r;
            sp_d_r <= {hi_r, rx_r};
          end
          else
            out_d_r <= {hi_r, rx_r};
        end
        default:
          ;
      endcase
    end
  end

  assign O_CMD_READY = ready_r;
  assign O_RD_VALID = out_v_r;
  assign O_RD_DATA = out_d_r;
  assign O_NACK = nack_r;
  assign LINK.scl = scl_r;
  assign LINK.host_sda_o = 1'b0;
  assign LINK.host_sda_oe = oe_r;
endmodule // icd_host

/* test/icd_link_assertions.sv */
// wire-level checker for the two-wire link between the ends
`timescale 1ns/1ps
module icd_link_assertions #(
  parameter int CLK_DIV = 5
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // link wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  // one cycle of slack for the edge detect in the device
  localparam int LOW_MIN = 2 * CLK_DIV - 1;
  logic [15:0] low_cnt_r;

  // length of the running scl low phase, saturating
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || scl)
      low_cnt_r <= 16'h0000;
    else if (low_cnt_r != 16'hffff)
      low_cnt_r <= low_cnt_r + 16'h0001;
  end

  scl_low_len_a: assert property (
    $rose(scl) |-> low_cnt_r >= LOW_MIN)
    else $error("scl low phase too short");
  scl_high_len_a: assert property (
    $rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  dev_hold_high_a: assert property (
    scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data moved while scl high");
  dev_change_late_a: assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device data moved too soon after scl fall");
  start_by_host_a: assert property (
    $fell(sda) && scl && $past(scl) |-> host_sda_oe)
    else $error("start not made by host");
  stop_by_host_a: assert property (
    $rose(sda) && scl && $past(scl) |->
    $fell(host_sda_oe) && !dev_sda_oe)
    else $error("stop not made by host");
  open_drain_a: assert property (
    !host_sda_o && !dev_sda_o)
    else $error("data line driven high");
  reset_idle_a: assert property (
    $fell(I_RST) |-> scl && !host_sda_oe && !dev_sda_oe)
    else $error("link not idle after reset");

  // main traffic seen
  cover property ($rose(dev_sda_oe));
  cover property ($fell(sda) && scl);
  cover property ($rose(scl) && low_cnt_r > 16'h0028);
endmodule // icd_link_assertions

/* test/tb_io_channel_dac_adc_gpio_control.sv */
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module tb_io_channel_dac_adc_gpio_control;
  localparam int CLK_DIV = 5;
  localparam icd_pkg::icd_cmd_t WR = icd_pkg::CMD_WRITE;
  localparam icd_pkg::icd_cmd_t PT = icd_pkg::CMD_POINTER;
  localparam icd_pkg::icd_cmd_t RD = icd_pkg::CMD_READ;
  // chk: 0 none, 1 read word, 2 dac code of ch, 3 pin oe and level
  typedef struct packed {
    icd_pkg::icd_cmd_t kind;
    logic [7:0] ptr;
    logic [15:0] data;
    logic [1:0] chk;
    logic [2:0] ch;
    logic [15:0] exp;
  } icd_row_t;
  localparam icd_row_t ROWS [15] = '{
    '{WR, 8'h07, 16'h0001, 2'h0, 3'h0, 16'h0000},
    '{WR, 8'h13, 16'h0abc, 2'h2, 3'h3, 16'h0000},
    '{PT, 8'h53, 16'h0000, 2'h0, 3'h0, 16'h0000},
    '{RD, 8'h00, 16'h0001, 2'h1, 3'h0, 16'hbabc},
    '{WR, 8'h07, 16'h0002, 2'h2, 3'h3, 16'h0abc},
    '{WR, 8'h15, 16'h0123, 2'h2, 3'h5, 16'h0000},
    '{WR, 8'h07, 16'h0000, 2'h0, 3'h0, 16'h0000},
    '{WR, 8'h16, 16'h07ff, 2'h2, 3'h6, 16'h07ff},
    '{WR, 8'h07, 16'h0003, 2'h0, 3'h0, 16'h0000},
    '{WR, 8'h14, 16'h0055, 2'h2, 3'h4, 16'h0000},
    '{PT, 8'h54, 16'h0000, 2'h0, 3'h0, 16'h0000},
    '{RD, 8'h00, 16'h0001, 2'h1, 3'h0, 16'hc055},
    '{WR, 8'h08, 16'h00f0, 2'h0, 3'h0, 16'h0000},
    '{WR, 8'h0c, 16'h00c0, 2'h3, 3'h0, 16'hf000},
    '{WR, 8'h09, 16'h005a, 2'h3, 3'h0, 16'hb010}
  };
  logic I_REF_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic cmd_valid = 1'b0;
  icd_pkg::icd_cmd_t cmd_kind = icd_pkg::CMD_WRITE;
  logic [7:0] cmd_ptr = 8'h00;
  logic [15:0] cmd_data = 16'h0000;
  logic rd_ready = 1'b0;
  logic cmd_ready;
  logic rd_valid;
  logic nack;
  logic [15:0] rd_data;
  logic [3:0] adc_ch;
  logic adc_start;
  logic [95:0] dac_codes;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [11:0] adc_data;
  int mismatches = 0;
  int compares = 0;
  int starts = 0;
  int nacks = 0;
  int s0;
  logic [11:0] dac_w;
  icd_link_if link ();

  // converter stand-in: result names the slot it came from
  assign adc_data = {adc_ch, 8'h5a};
  always #4 I_REF_CLK = ~I_REF_CLK;
  always @(posedge I_REF_CLK)
    if (adc_start === 1'b1)
      starts++;
  // any refused byte shows as a nack; none is expected in this run
  always @(posedge I_REF_CLK)
    if (!I_RST && nack !== 1'b0)
      nacks++;

  icd_host #(.CLK_DIV(CLK_DIV)) icd_host_inst (.I_REF_CLK(I_REF_CLK),
    .I_RST(I_RST), .LINK(link), .I_CMD_VALID(cmd_valid),
    .I_CMD_KIND(cmd_kind), .I_CMD_PTR(cmd_ptr), .I_CMD_DATA(cmd_data),
    .O_CMD_READY(cmd_ready), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data),
    .I_RD_READY(rd_ready), .O_NACK(nack));
  icd_device icd_device_inst (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
    .LINK(link), .I_ADC_DATA(adc_data), .O_ADC_CH(adc_ch),
    .O_ADC_START(adc_start), .O_DAC_CODES(dac_codes),
    .O_IO_PIN_OUT(pin_out), .O_IO_PIN_OE(pin_oe));
  icd_link_assertions #(.CLK_DIV(CLK_DIV)) icd_link_assertions_inst (
    .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .scl(link.scl),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .sda(link.sda));

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for the host to be idle, callers sit just after an edge
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 9000)
    begin
      @(posedge I_REF_CLK);
      #1;
      n++;
    end
    if (cmd_ready !== 1'b1)
      mismatches++;
  endtask

  task automatic cmd(input icd_pkg::icd_cmd_t k, input logic [7:0] p,
                     input logic [15:0] d);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_ptr = p;
    cmd_data = d;
    @(posedge I_REF_CLK);
    #1;
    cmd_valid = 1'b0;
  endtask

  // frame done plus the few cycles the register effects need
  task automatic settle();
    wait_ready();
    repeat (4) @(posedge I_REF_CLK);
    #1;
  endtask

  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 3000)
    begin
      @(posedge I_REF_CLK);
      #1;
      n++;
    end
    // stale data after a lost word must not pass
    if (rd_valid !== 1'b1)
      mismatches++;
    check(rd_data, exp);
    rd_ready = 1'b1;
    @(posedge I_REF_CLK);
    #1;
    rd_ready = 1'b0;
    // one idle edge so a following pop never re-raises ready at once
    @(posedge I_REF_CLK);
    #1;
  endtask

  task automatic adc_read(input logic [15:0] n);
    cmd(PT, 8'h40, 16'h0000);
    cmd(RD, 8'h00, n);
  endtask

  function automatic logic [15:0] adc_word(input logic [3:0] s);
    adc_word = {1'b0, (s == 4'h8) ? 3'b000 : s[2:0], s, 8'h5a};
  endfunction

  // watchdog, well above the expected run length
  initial
  begin
    repeat (90000) @(posedge I_REF_CLK);
    mismatches++;
    final_report();
  end

  initial
  begin
    repeat (4) @(posedge I_REF_CLK);
    #1;
    I_RST = 1'b0;
    check({12'h000, adc_ch}, 16'h000f);
    check({15'h0000, |dac_codes}, 16'h0000);
    check({pin_oe, pin_out}, 16'h0000);
    foreach (ROWS[i])
    begin
      cmd(ROWS[i].kind, ROWS[i].ptr, ROWS[i].data);
      if (ROWS[i].chk == 2'h1)
        pop(ROWS[i].exp);
      settle();
      dac_w = dac_codes[12 * ROWS[i].ch +: 12];
      if (ROWS[i].chk == 2'h2)
        check({4'h0, dac_w}, ROWS[i].exp);
      if (ROWS[i].chk == 2'h3)
        check({pin_oe, pin_out & pin_oe}, ROWS[i].exp);
    end
    // no repeat: buffer fills and stalls the link before draining
    cmd(WR, 8'h02, 16'h0085);
    settle();
    check({12'h000, adc_ch}, 16'h0000);
    s0 = starts;
    adc_read(16'h0004);
    repeat (1500) @(posedge I_REF_CLK);
    #1;
    pop(adc_word(4'h0));
    pop(adc_word(4'h2));
    pop(adc_word(4'h7));
    pop(adc_word(4'h7));
    settle();
    check(16'(starts - s0), 16'h0003);
    // repeat with temperature slot last, then round again
    cmd(WR, 8'h02, 16'h0301);
    adc_read(16'h0003);
    pop(adc_word(4'h0));
    pop(adc_word(4'h8));
    pop(adc_word(4'h0));
    settle();
    // new sequence drops the pending channel, then halt
    cmd(WR, 8'h02, 16'h0009);
    adc_read(16'h0001);
    pop(adc_word(4'h0));
    cmd(WR, 8'h02, 16'h0030);
    adc_read(16'h0001);
    pop(adc_word(4'h4));
    cmd(WR, 8'h02, 16'h0000);
    settle();
    s0 = starts;
    adc_read(16'h0001);
    pop(adc_word(4'h4));
    settle();
    check(16'(starts - s0), 16'h0000);
    // mid-run reset: defaults return and the link still works after
    I_RST = 1'b1;
    repeat (4) @(posedge I_REF_CLK);
    #1;
    check({cmd_ready, rd_valid, 10'h000, adc_ch}, 16'h000f);
    check({15'h0000, |dac_codes}, 16'h0000);
    check({pin_oe, pin_out}, 16'h0000);
    I_RST = 1'b0;
    cmd(PT, 8'h53, 16'h0000);
    cmd(RD, 8'h00, 16'h0001);
    pop(16'hb000);
    settle();
    check(16'(nacks), 16'h0000);
    final_report();
  end
endmodule // tb_io_channel_dac_adc_gpio_control
